/* core/ext_ops_unit.sv */
// Execute unit for add-literal-to-pointer, its frame-return variant and call via accumulator
// ****************************************************************
// Summary of operation
// ****************************************************************
// Summary of operation
// - Selects 0..2: add 6-bit literal to pointer
// - Select 11 means frame-return variant
// - Add literal to frame pointer, then return
// - Frame return: one word, two cycles, nop
// - Call via accumulator pushes pc plus two
// - Low pc byte taken from accumulator
// - Latches fill pc high and upper bytes
// - Call: two cycles, second one a nop
// - Call saves no accumulator, status or bank
// - Frame return touches only frame pointer
// - Extended instructions only when enable set
`timescale 1ns/1ps

module ext_ops_unit
    import ext_ops_pkg::*;
#(
    parameter int NUM_POINTERS = NUM_PTR
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic extended_set_enable,
    input ext_ops_pkg::insn_type insn,
    input wire logic [7:0] working_accumulator_reg,
    input wire logic [7:0] program_latch_high,
    input wire logic [ext_ops_pkg::PCU_W-1:0] program_latch_upper,
    input wire logic [ext_ops_pkg::PC_W-1:0] return_stack_top,
    output ext_ops_pkg::stack_req_type stack_req,
    output ext_ops_pkg::pc_load_type pc_load,
    output logic fetch_hold,
    output logic insn_done,
    output logic [ext_ops_pkg::PTR_W-1:0] file_select_pointer [NUM_POINTERS]
);
    import ext_ops_pkg::*;

    // ****************************************************************
    // Timing overview
    // ****************************************************************
    // Edge 0: a word is taken when valid, enabled and the unit is idle.
    // Edge 1: pointer sums, stack request, pc load and fetch hold appear.
    // Edge 2: a two-cycle op reports done; a word offered in the nop cycle
    // is dropped, so fetch must present it again once the hold is gone.
    // Pointer sums wrap at the pointer width, as the data space does.
    // Status flags live outside this unit and are never driven from here.
    // A word matches at most one of the three ops, so the pointer add and
    // the call need no priority between them.
    // The return stack itself sits outside; this unit only asks for a push
    // or a pop and supplies the address to push.

    // ****************************************************************
    // Decode
    // ****************************************************************
    exec_state_type state_q;
    exec_state_type state_d;
    logic is_add_ptr;
    logic is_frame_ret;
    logic is_call_acc;
    logic [SEL_W-1:0] sel;
    logic [LIT_W-1:0] lit;
    logic issue;
    logic op_hi_hit;
    logic frame_hit;
    logic call_hit;

    // ****************************************************************
    // Field extraction
    // ****************************************************************
    // Select and literal are sliced from every word; they only matter when
    // the high byte matches, so they need no qualification here
    assign sel = insn.word[SEL_LSB +: SEL_W];
    assign lit = insn.word[LIT_W-1:0];

    // New words are taken only when no second cycle is pending
    assign issue = insn.valid && (state_q == EXEC_ST);

    // Raw pattern matches, before enable and issue gating
    assign op_hi_hit = (insn.word[INSN_W-1:OP_HI_LSB] == ADD_PTR_HIGH);
    assign frame_hit = (sel == FRAME_SEL);
    assign call_hit = (insn.word == CALL_ACC_OP);

    // ****************************************************************
    // Decode gating
    // ****************************************************************
    // With the extension disabled every word falls through untouched, so
    // the standard decoder keeps these encodings to itself
    always_comb
    begin
        is_add_ptr = 1'b0;
        is_frame_ret = 1'b0;
        is_call_acc = 1'b0;
        if (issue && extended_set_enable)
        begin
            if (op_hi_hit)
            begin
                is_frame_ret = frame_hit;
                is_add_ptr = !frame_hit;
            end
            if (call_hit)
            begin
                is_call_acc = 1'b1;
            end
        end
    end

    // ****************************************************************
    // Sequencing
    // ****************************************************************
    always_comb
    begin
        state_d = EXEC_ST;
        unique case (state_q)
            EXEC_ST:
            begin
                if (is_frame_ret)
                begin
                    state_d = FRAME_NOP_ST;
                end
                else if (is_call_acc)
                begin
                    state_d = CALL_NOP_ST;
                end
            end
            FRAME_NOP_ST:
            begin
                // Nothing issues; the return target is being fetched
                state_d = EXEC_ST;
            end
            CALL_NOP_ST:
            begin
                // Nothing issues; the call target is being fetched
                state_d = EXEC_ST;
            end
            default:
            begin
                // The unused code recovers to idle rather than locking up
                state_d = EXEC_ST;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state_q <= EXEC_ST;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ****************************************************************
    // Fetch hold and completion
    // ****************************************************************
    // Second cycle does no work; fetch is held for one cycle
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            fetch_hold <= 1'b0;
        end
        else
        begin
            fetch_hold <= is_frame_ret || is_call_acc;
        end
    end

    // Done follows a pointer add at once, or the nop cycle of a two-cycle op
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            insn_done <= 1'b0;
        end
        else
        begin
            insn_done <= is_add_ptr || (state_q != EXEC_ST);
        end
    end

    // ****************************************************************
    // Pointer registers
    // ****************************************************************
    // Add is modulo the pointer width; no flags exist here to alter
    generate
        for (genvar i = 0; i < NUM_POINTERS; i++)
        begin : g_ptr
            always_ff @(posedge core_clk)
            begin
                if (sys_rst)
                begin
                    file_select_pointer[i] <= PTR_RESET;
                end
                else if (is_add_ptr && (sel == SEL_W'(i)))
                begin
                    file_select_pointer[i] <= file_select_pointer[i]
                        + PTR_W'(lit);
                end
                else if (is_frame_ret && (FRAME_PTR_IDX == SEL_W'(i)))
                begin
                    file_select_pointer[i] <= file_select_pointer[i]
                        + PTR_W'(lit);
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Return stack and program counter
    // ****************************************************************
    // Accumulator, status and bank are never written here
    logic [PC_W-1:0] ret_addr;
    logic [PC_W-1:0] call_target;

    // Wraps at the top of program space, as the fetch counter does
    assign ret_addr = insn.pc + PC_STEP;
    // The accumulator replaces the low byte outright; nothing is added to it
    assign call_target = {program_latch_upper, program_latch_high,
        working_accumulator_reg};

    // Stack request; the address is only meaningful with a push
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            stack_req <= '0;
        end
        else
        begin
            stack_req.push <= is_call_acc;
            stack_req.pop <= is_frame_ret;
            stack_req.addr <= ret_addr;
        end
    end

    // Redirect; the target is only meaningful with load
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            pc_load <= '0;
        end
        else
        begin
            pc_load.load <= is_call_acc || is_frame_ret;
            if (is_frame_ret)
            begin
                pc_load.target <= return_stack_top;
            end
            else
            begin
                pc_load.target <= call_target;
            end
        end
    end

endmodule : ext_ops_unit

/* core/ext_ops_pkg.sv */
// Package: encodings, widths and carriers for the extended pointer and call instructions
package ext_ops_pkg;

    localparam int INSN_W = 16;
    localparam int PTR_W = 12;
    localparam int PC_W = 21;
    localparam int LIT_W = 6;
    localparam int SEL_W = 2;
    localparam int NUM_PTR = 3;

    // Opcode patterns
    localparam logic [7:0] ADD_PTR_HIGH = 8'hE8;
    localparam logic [INSN_W-1:0] CALL_ACC_OP = 16'h0014;
    localparam logic [SEL_W-1:0] FRAME_SEL = 2'h3;
    localparam logic [SEL_W-1:0] FRAME_PTR_IDX = 2'h2;

    // Opcode field positions
    localparam int OP_HI_LSB = 8;
    localparam int SEL_LSB = 6;

    // Program counter byte positions
    localparam int PCH_LSB = 8;
    localparam int PCU_LSB = 16;
    localparam int PCU_W = 5;

    // Return address is one word further on, two bytes
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

    localparam logic [PTR_W-1:0] PTR_RESET = 12'h000;
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;

    typedef enum logic [1:0] {
        EXEC_ST = 2'b00,
        FRAME_NOP_ST = 2'b01,
        CALL_NOP_ST = 2'b10
    } exec_state_type;

    // Instruction issued by the fetch stage
    typedef struct packed {
        logic valid;
        logic [INSN_W-1:0] word;
        logic [PC_W-1:0] pc;
    } insn_type;

    // Request to the hardware return stack
    typedef struct packed {
        logic push;
        logic pop;
        logic [PC_W-1:0] addr;
    } stack_req_type;

    // Program counter redirect to the fetch stage
    typedef struct packed {
        logic load;
        logic [PC_W-1:0] target;
    } pc_load_type;

endpackage : ext_ops_pkg

/* sim/ext_ops_unit_sva.sv */
// Checker of the extended pointer and call unit
`timescale 1ns/1ps
module ext_ops_unit_sva
    import ext_ops_pkg::*;
#(
    parameter int NUM_POINTERS = NUM_PTR
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic extended_set_enable,
    input ext_ops_pkg::insn_type insn,
    input wire logic [7:0] working_accumulator_reg,
    input wire logic [7:0] program_latch_high,
    input wire logic [ext_ops_pkg::PCU_W-1:0] program_latch_upper,
    input wire logic [ext_ops_pkg::PC_W-1:0] return_stack_top,
    input ext_ops_pkg::stack_req_type stack_req,
    input ext_ops_pkg::pc_load_type pc_load,
    input wire logic fetch_hold,
    input wire logic insn_done,
    input wire logic [ext_ops_pkg::PTR_W-1:0] file_select_pointer [NUM_POINTERS]
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    // Issue is refused only in the nop cycle, marked by fetch_hold
    wire go = insn.valid && extended_set_enable && !fetch_hold;
    wire add = go && insn.word[15:8] == ADD_PTR_HIGH;
    wire frm = add && insn.word[7:6] == FRAME_SEL;
    wire call = go && insn.word == CALL_ACC_OP;
    wire [PTR_W-1:0] lit = {6'h0, insn.word[5:0]};
    // ****
    // Assertions
    // ****
    pointer_add_a: assert property (
        add && insn.word[7:6] == 2'h1 |=> insn_done && !fetch_hold &&
        file_select_pointer[1] == $past(file_select_pointer[1]) + $past(lit))
        else $error("pointer add wrong");
    frame_add_a: assert property (
        frm |=> stack_req.pop &&
        file_select_pointer[2] == $past(file_select_pointer[2]) + $past(lit))
        else $error("frame add wrong");
    frame_return_a: assert property (
        frm |=> pc_load.load && pc_load.target == $past(return_stack_top))
        else $error("frame return wrong");
    frame_only_a: assert property (
        frm |=> $stable(file_select_pointer[0]) && $stable(file_select_pointer[1]))
        else $error("other pointer moved");
    call_push_a: assert property (
        call |=> stack_req.push && stack_req.addr == $past(insn.pc) + PC_STEP)
        else $error("call push wrong");
    call_target_a: assert property (
        call |=> pc_load.load && pc_load.target == {$past(program_latch_upper),
        $past(program_latch_high), $past(working_accumulator_reg)})
        else $error("call target wrong");
    two_cycle_a: assert property (
        frm || call |=> fetch_hold ##1 (insn_done && !fetch_hold && !pc_load.load))
        else $error("nop cycle wrong");
    gate_off_a: assert property (
        insn.valid && !extended_set_enable |=> !pc_load.load && !stack_req.push &&
        $stable(file_select_pointer[2]))
        else $error("disabled op acted");
endmodule : ext_ops_unit_sva

/* sim/extended_pointer_call_ops_test.sv */
// Self-checking bench of the extended pointer and call unit
`timescale 1ns/1ps
module extended_pointer_call_ops_test;
    import ext_ops_pkg::*;
    logic core_clk = '0, sys_rst = 1'h1, extended_set_enable = '0;
    insn_type insn = '0;
    logic [7:0] working_accumulator_reg = '0, program_latch_high = '0;
    logic [PCU_W-1:0] program_latch_upper = '0;
    logic [PC_W-1:0] return_stack_top = '0;
    stack_req_type stack_req;
    pc_load_type pc_load;
    logic fetch_hold, insn_done;
    logic [PTR_W-1:0] file_select_pointer [NUM_PTR], fp [NUM_PTR] = '{default: '0};
    int err_total = 0, compares = 0, cyc = 0, seed = 32'h33de;
    ext_ops_unit dut (.core_clk, .sys_rst, .extended_set_enable, .insn,
        .working_accumulator_reg, .program_latch_high, .program_latch_upper,
        .return_stack_top, .stack_req, .pc_load, .fetch_hold, .insn_done,
        .file_select_pointer);
    // ****
    // Tasks
    // ****
    task automatic chk(input logic [PC_W-1:0] g, input logic [PC_W-1:0] e);
        compares++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    function automatic logic [PC_W-1:0] call_target(input logic [PCU_W-1:0] u,
        input logic [7:0] h, input logic [7:0] a);
        return {u, h, a};
    endfunction : call_target
    task automatic finish_test;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    // Valid is left high after a one-cycle op; the next op rewrites it
    task automatic op(input logic [15:0] w, input logic en);
        logic ad, two;
        logic [PC_W-1:0] tg;
        insn = {1'h1, w, PC_W'($random(seed))};
        extended_set_enable = en;
        {working_accumulator_reg, program_latch_high} = 16'($random(seed));
        program_latch_upper = PCU_W'($random(seed));
        return_stack_top = PC_W'($random(seed));
        ad = en && w[15:8] == ADD_PTR_HIGH;
        two = en && (w == CALL_ACC_OP || ad && w[7:6] == FRAME_SEL);
        tg = ad ? return_stack_top : call_target(program_latch_upper,
            program_latch_high, working_accumulator_reg);
        if (ad)
            fp[w[7:6] == FRAME_SEL ? FRAME_PTR_IDX : w[7:6]] += {6'h0, w[5:0]};
        @(negedge core_clk);
        chk(pc_load.load, two);
        chk(stack_req.push, two && !ad);
        chk(stack_req.pop, two && ad);
        chk(fetch_hold, two);
        chk(insn_done, ad && !two);
        chk(two ? pc_load.target : tg, tg);
        chk(two && !ad ? stack_req.addr : insn.pc + PC_STEP, insn.pc + PC_STEP);
        for (int i = 0; i < NUM_PTR; i++)
            chk(file_select_pointer[i], fp[i]);
        if (two)
        begin
            @(negedge core_clk);
            chk(insn_done, 1'h1);
            chk(pc_load.load, 1'h0);
            insn.valid = 1'h0;
            @(negedge core_clk);
        end
    endtask : op
    initial
    begin
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            finish_test;
        end
    end
    initial
    begin
        logic [31:0] r;
        repeat (3) @(negedge core_clk);
        sys_rst = 1'h0;
        op(16'hE8A3, 1'h1);
        op(16'hE8FF, 1'h1);
        op(CALL_ACC_OP, 1'h1);
        op(CALL_ACC_OP, 1'h0);
        op(16'hE87F, 1'h0);
        $display("corner test done");
        repeat (1500)
        begin
            r = $random(seed);
            op(r[1:0] == 2'h0 ? CALL_ACC_OP : r[1:0] == 2'h1 ? r[31:16] :
                {ADD_PTR_HIGH, r[15:8]}, r[4:2] != 3'h0);
        end
        $display("random test done");
        finish_test;
    end
endmodule : extended_pointer_call_ops_test
bind ext_ops_unit ext_ops_unit_sva #(.NUM_POINTERS(NUM_POINTERS)) sva_i (.core_clk,
    .sys_rst, .extended_set_enable, .insn, .working_accumulator_reg, .program_latch_high,
    .program_latch_upper, .return_stack_top, .stack_req, .pc_load, .fetch_hold,
    .insn_done, .file_select_pointer);
